// ==== logic/cke_pair_ctrl.sv ====
// Purpose: Clock-enable control for one pair of memory rows
// Assumes: Sequencer only issues to a pair whose clock enable is high
// Notes:   A wake request outranks power-down entry
`timescale 1ns/1ps
module cke_pair_ctrl (
  input  wire logic CLK_I,
  input  wire logic RSTN_I,
  input  wire logic enable_i,
  input  wire logic closed_i,
  input  wire logic wake_i,
  output logic      cke_o
);
  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      cke_o <= 1'b1;
    end else if (wake_i || !enable_i) begin
      cke_o <= 1'b1;
    end else if (closed_i) begin
      cke_o <= 1'b0;
    end
  end
endmodule

// ==== logic/ddr_cfg_pkg.sv ====
// Purpose: Shared constants for the DDR timing and mode configuration block
// Assumes: 50 MHz DRAM clock, AXI4-Lite register access with 32-bit data
// Notes:   Offsets are byte addresses; one register per aligned word
package ddr_cfg_pkg;

  // ==========================================================================
  // Bus and clock
  // ==========================================================================
  localparam int          ADDR_W        = 8;
  localparam int          CNT_W         = 12;
  localparam int          CLK_PERIOD_NS = 20;
  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;

  // ==========================================================================
  // Register map
  // ==========================================================================
  localparam logic [ADDR_W-1:0] DRAM_TIMING_OFS = 8'h78;
  localparam logic [ADDR_W-1:0] DRAM_MODE_OFS   = 8'h7c;
  localparam logic [ADDR_W-1:0] CTRL_STATUS_OFS = 8'h80;
  localparam logic [31:0]       DRAM_TIMING_RST = 32'h0000_0010;
  localparam logic [31:0]       DRAM_MODE_RST   = 32'h0000_0000;
  localparam logic [31:0]       DRAM_TIMING_WM  = 32'h0007_0635;
  localparam logic [31:0]       DRAM_MODE_WM    = 32'hff30_0700;

  // ==========================================================================
  // Field positions
  // ==========================================================================
  localparam int IDLE_LSB = 16;
  localparam int TRAS_LSB = 9;
  localparam int CL_LSB   = 4;
  localparam int TRCD_BIT = 2;
  localparam int TRP_BIT  = 0;
  localparam int REV_LSB  = 30;
  localparam int INIT_BIT = 29;
  localparam int DPD_BIT  = 28;
  localparam int ROWS_LSB = 24;
  localparam int DIM_LSB  = 20;
  localparam int RRS_LSB  = 8;

  // ==========================================================================
  // Encodings and timing counts (DRAM clocks; the REF_*_NS refresh intervals are in ns)
  // ==========================================================================
  localparam logic [1:0]       CL_2P5    = 2'h0;
  localparam logic [1:0]       DIM_ECC   = 2'h2;
  localparam logic [CNT_W-1:0] TRAS_C0   = 12'h007;
  localparam logic [CNT_W-1:0] TRAS_C1   = 12'h006;
  localparam logic [CNT_W-1:0] TRAS_C2   = 12'h005;
  localparam logic [CNT_W-1:0] TRCD_C0   = 12'h003;
  localparam logic [CNT_W-1:0] TRCD_C1   = 12'h002;
  localparam logic [CNT_W-1:0] TRP_C0    = 12'h003;
  localparam logic [CNT_W-1:0] TRP_C1    = 12'h002;
  localparam logic [CNT_W-1:0] IDLE_C1   = 12'h000;
  localparam logic [CNT_W-1:0] IDLE_C2   = 12'h008;
  localparam logic [CNT_W-1:0] IDLE_C3   = 12'h010;
  localparam logic [CNT_W-1:0] IDLE_C4   = 12'h040;
  localparam logic [CNT_W-1:0] REF_FAST  = 12'h040;
  localparam int               REF_A_NS  = 15600;
  localparam int               REF_B_NS  = 7800;
  localparam int               REF_C_NS  = 64000;
  localparam logic [CNT_W-1:0] REF_A_CYC = CNT_W'(REF_A_NS / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] REF_B_CYC = CNT_W'(REF_B_NS / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] REF_C_CYC = CNT_W'(REF_C_NS / CLK_PERIOD_NS);
  localparam int               CAS_PIPE  = 3;
  localparam int               NUM_PAIRS = 4;

  typedef enum logic [2:0] {
    CMD_NOP     = 3'h0,
    CMD_ACT     = 3'h1,
    CMD_RD      = 3'h2,
    CMD_WR      = 3'h3,
    CMD_PRE_ALL = 3'h4,
    CMD_REF     = 3'h5
  } cmd_e;

endpackage

// ==== logic/ddr_timing_mode_config.sv ====
// Purpose: DDR command timing and mode configuration with a small command sequencer
// Assumes: One open row at a time; requests held stable until accepted
// Notes:   Registers reached over AXI4-Lite; unmapped addresses answer SLVERR
// Overview of operation
// - After the programmed idle count with no work, all open pages are precharged.
// - A precharge follows an activate by no fewer than the programmed tRAS clocks.
// - Read data is captured a CAS latency of 2 or 2.5 clocks after the read is sampled.
// - A read or write follows its row activate by the programmed tRCD clocks.
// - An activate follows a precharge by the programmed tRP clocks.
// - With power-down on, a fully precharged row pair sleeps and wakes on access.
// - Power-down is entered by dropping clock enable and left by raising it.
// - Data-integrity code 00 runs without checking and 10 checks and corrects.
// - Refreshes are issued at the interval chosen by the refresh-rate field.
`timescale 1ns/1ps
module ddr_timing_mode_config (
  input  wire logic                         CLK_I,
  input  wire logic                         RSTN_I,
  input  wire logic [ddr_cfg_pkg::ADDR_W-1:0] AWADDR_I,
  input  wire logic                         AWVALID_I,
  output logic                              AWREADY_O,
  input  wire logic [31:0]                  WDATA_I,
  input  wire logic [3:0]                   WSTRB_I,
  input  wire logic                         WVALID_I,
  output logic                              WREADY_O,
  output logic [1:0]                        BRESP_O,
  output logic                              BVALID_O,
  input  wire logic                         BREADY_I,
  input  wire logic [ddr_cfg_pkg::ADDR_W-1:0] ARADDR_I,
  input  wire logic                         ARVALID_I,
  output logic                              ARREADY_O,
  output logic [31:0]                       RDATA_O,
  output logic [1:0]                        RRESP_O,
  output logic                              RVALID_O,
  input  wire logic                         RREADY_I,
  input  wire logic                         REQ_VALID_I,
  output logic                              REQ_READY_O,
  input  wire logic                         REQ_WRITE_I,
  input  wire logic [1:0]                   REQ_PAIR_I,
  input  wire logic [1:0]                   REQ_BANK_I,
  input  wire logic [12:0]                  REQ_ROW_I,
  output ddr_cfg_pkg::cmd_e                 CMD_O,
  output logic [1:0]                        CMD_PAIR_O,
  output logic [1:0]                        CMD_BANK_O,
  output logic [12:0]                       CMD_ROW_O,
  output logic [ddr_cfg_pkg::NUM_PAIRS-1:0] CKE_O,
  output logic                              RD_CAPTURE_O,
  output logic                              RD_HALF_O,
  output logic                              ECC_CHECK_O,
  output logic                              INIT_DONE_O
);
  import ddr_cfg_pkg::*;

  // ==========================================================================
  // Registers and bus state
  // ==========================================================================
  logic [31:0]       dram_timing_reg;
  logic [31:0]       dram_mode_reg;
  logic              aw_held;
  logic              w_held;
  logic [ADDR_W-1:0] aw_addr;
  logic [31:0]       w_data;
  logic [3:0]        w_strb;
  logic              do_write;
  logic [31:0]       strobe_mask;
  logic [31:0]       rd_word;
  logic              rd_hit;
  logic              wr_hit;

  // ==========================================================================
  // Sequencer state
  // ==========================================================================
  typedef enum logic [0:0] {
    ST_CLOSED = 1'b0,
    ST_OPEN   = 1'b1
  } row_state_e;

  row_state_e        row_state;
  cmd_e              next_cmd;
  logic [1:0]        open_pair;
  logic [1:0]        open_bank;
  logic [12:0]       open_row;
  logic              row_hit;
  logic              busy;
  logic              refresh_due;
  logic              ref_done;
  logic              tras_done;
  logic              trcd_done;
  logic              trp_done;
  logic              idle_done;
  logic              idle_armed;
  logic              ref_enabled;
  logic [CNT_W-1:0]  tras_cyc;
  logic [CNT_W-1:0]  trcd_cyc;
  logic [CNT_W-1:0]  trp_cyc;
  logic [CNT_W-1:0]  idle_cyc;
  logic [CNT_W-1:0]  ref_cyc;
  logic [CAS_PIPE-1:0] cas_pipe;
  logic              wake_all;

  // ==========================================================================
  // Write channel
  // ==========================================================================
  assign AWREADY_O = !aw_held && !BVALID_O;
  assign WREADY_O  = !w_held && !BVALID_O;
  assign do_write  = aw_held && w_held && !BVALID_O;
  assign wr_hit    = (aw_addr == DRAM_TIMING_OFS) || (aw_addr == DRAM_MODE_OFS);

  always_comb begin
    for (int b = 0; b < 4; b++) begin
      strobe_mask[8*b +: 8] = {8{w_strb[b]}};
    end
  end

  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      aw_held <= 1'b0;
      aw_addr <= '0;
    end else if (AWVALID_I && AWREADY_O) begin
      aw_held <= 1'b1;
      aw_addr <= AWADDR_I;
    end else if (do_write) begin
      aw_held <= 1'b0;
    end
  end

  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      w_held <= 1'b0;
      w_data <= '0;
      w_strb <= '0;
    end else if (WVALID_I && WREADY_O) begin
      w_held <= 1'b1;
      w_data <= WDATA_I;
      w_strb <= WSTRB_I;
    end else if (do_write) begin
      w_held <= 1'b0;
    end
  end

  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      BVALID_O <= 1'b0;
      BRESP_O  <= RESP_OKAY;
    end else if (do_write) begin
      BVALID_O <= 1'b1;
      BRESP_O  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (BREADY_I) begin
      BVALID_O <= 1'b0;
    end
  end

  // Reserved bits stay zero; version and row-limit fields are stored as written
  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      dram_timing_reg <= DRAM_TIMING_RST;
      dram_mode_reg   <= DRAM_MODE_RST;
    end else if (do_write && aw_addr == DRAM_TIMING_OFS) begin
      dram_timing_reg <= (dram_timing_reg & ~(strobe_mask & DRAM_TIMING_WM))
                       | (w_data & strobe_mask & DRAM_TIMING_WM);
    end else if (do_write && aw_addr == DRAM_MODE_OFS) begin
      dram_mode_reg <= (dram_mode_reg & ~(strobe_mask & DRAM_MODE_WM))
                     | (w_data & strobe_mask & DRAM_MODE_WM);
    end
  end

  // ==========================================================================
  // Read channel
  // ==========================================================================
  assign ARREADY_O = !RVALID_O;

  always_comb begin
    rd_hit  = 1'b1;
    rd_word = '0;
    unique case (ARADDR_I)
      DRAM_TIMING_OFS: rd_word = dram_timing_reg;
      DRAM_MODE_OFS:   rd_word = dram_mode_reg;
      CTRL_STATUS_OFS: rd_word = {22'h0, cas_pipe[0], CMD_O, refresh_due,
                                  row_state == ST_OPEN, CKE_O};
      default:         rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      RVALID_O <= 1'b0;
      RDATA_O  <= '0;
      RRESP_O  <= RESP_OKAY;
    end else if (ARVALID_I && ARREADY_O) begin
      RVALID_O <= 1'b1;
      RDATA_O  <= rd_word;
      RRESP_O  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (RREADY_I) begin
      RVALID_O <= 1'b0;
    end
  end

  // ==========================================================================
  // Field decode into clock counts
  // ==========================================================================
  always_comb begin
    unique case (dram_timing_reg[TRAS_LSB +: 2])
      2'h1:    tras_cyc = TRAS_C1;
      2'h2:    tras_cyc = TRAS_C2;
      default: tras_cyc = TRAS_C0;
    endcase
    trcd_cyc   = dram_timing_reg[TRCD_BIT] ? TRCD_C1 : TRCD_C0;
    trp_cyc    = dram_timing_reg[TRP_BIT] ? TRP_C1 : TRP_C0;
    idle_armed = 1'b1;
    unique case (dram_timing_reg[IDLE_LSB +: 3])
      3'h1:    idle_cyc = IDLE_C1;
      3'h2:    idle_cyc = IDLE_C2;
      3'h3:    idle_cyc = IDLE_C3;
      3'h4:    idle_cyc = IDLE_C4;
      default: begin
        idle_cyc   = '0;
        idle_armed = 1'b0;
      end
    endcase
    ref_enabled = 1'b1;
    unique case (dram_mode_reg[RRS_LSB +: 3])
      3'h1:    ref_cyc = REF_A_CYC;
      3'h2:    ref_cyc = REF_B_CYC;
      3'h3:    ref_cyc = REF_C_CYC;
      3'h7:    ref_cyc = REF_FAST;
      default: begin
        ref_cyc     = '0;
        ref_enabled = 1'b0;
      end
    endcase
  end

  assign ECC_CHECK_O = (dram_mode_reg[DIM_LSB +: 2] == DIM_ECC);
  assign INIT_DONE_O = dram_mode_reg[INIT_BIT];

  // ==========================================================================
  // Spacing timers
  // ==========================================================================
  spacing_timer u_tras (
    .CLK_I   (CLK_I),
    .RSTN_I  (RSTN_I),
    .load_i  (next_cmd == CMD_ACT),
    .value_i (tras_cyc),
    .done_o  (tras_done)
  );

  spacing_timer u_trcd (
    .CLK_I   (CLK_I),
    .RSTN_I  (RSTN_I),
    .load_i  (next_cmd == CMD_ACT),
    .value_i (trcd_cyc),
    .done_o  (trcd_done)
  );

  spacing_timer u_trp (
    .CLK_I   (CLK_I),
    .RSTN_I  (RSTN_I),
    .load_i  (next_cmd == CMD_PRE_ALL || next_cmd == CMD_REF),
    .value_i (trp_cyc),
    .done_o  (trp_done)
  );

  spacing_timer u_idle (
    .CLK_I   (CLK_I),
    .RSTN_I  (RSTN_I),
    .load_i  (busy || next_cmd != CMD_NOP),
    .value_i (idle_cyc),
    .done_o  (idle_done)
  );

  spacing_timer u_refi (
    .CLK_I   (CLK_I),
    .RSTN_I  (RSTN_I),
    .load_i  (next_cmd == CMD_REF || !ref_enabled),
    .value_i (ref_cyc),
    .done_o  (ref_done)
  );

  // Pending refresh; issuing a refresh outranks expiry
  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      refresh_due <= 1'b0;
    end else if (ref_enabled && ref_done && next_cmd != CMD_REF) begin
      refresh_due <= 1'b1;
    end else if (next_cmd == CMD_REF || !ref_enabled) begin
      refresh_due <= 1'b0;
    end
  end

  // ==========================================================================
  // Command choice
  // ==========================================================================
  assign row_hit  = (open_pair == REQ_PAIR_I) && (open_bank == REQ_BANK_I)
                  && (open_row == REQ_ROW_I);
  assign wake_all = refresh_due || (ref_enabled && ref_done);

  always_comb begin
    next_cmd    = CMD_NOP;
    REQ_READY_O = 1'b0;
    busy        = 1'b0;
    if (wake_all) begin
      busy = 1'b1;
      if (row_state == ST_OPEN) begin
        if (tras_done) begin
          next_cmd = CMD_PRE_ALL;
        end
      end else if (trp_done && (&CKE_O)) begin
        next_cmd = CMD_REF;
      end
    end else if (REQ_VALID_I) begin
      busy = 1'b1;
      if (CKE_O[REQ_PAIR_I]) begin
        if (row_state == ST_OPEN && row_hit) begin
          if (trcd_done) begin
            next_cmd    = REQ_WRITE_I ? CMD_WR : CMD_RD;
            REQ_READY_O = 1'b1;
          end
        end else if (row_state == ST_OPEN) begin
          if (tras_done) begin
            next_cmd = CMD_PRE_ALL;
          end
        end else if (trp_done) begin
          next_cmd = CMD_ACT;
        end
      end
    end else if (row_state == ST_OPEN && idle_armed && idle_done && tras_done) begin
      next_cmd = CMD_PRE_ALL;
    end
  end

  // ==========================================================================
  // Command outputs and open-row tracking
  // ==========================================================================
  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      CMD_O      <= CMD_NOP;
      CMD_PAIR_O <= '0;
      CMD_BANK_O <= '0;
      CMD_ROW_O  <= '0;
    end else begin
      CMD_O <= next_cmd;
      if (next_cmd == CMD_ACT || next_cmd == CMD_RD || next_cmd == CMD_WR) begin
        CMD_PAIR_O <= REQ_PAIR_I;
        CMD_BANK_O <= REQ_BANK_I;
        CMD_ROW_O  <= REQ_ROW_I;
      end
    end
  end

  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      row_state <= ST_CLOSED;
      open_pair <= '0;
      open_bank <= '0;
      open_row  <= '0;
    end else if (next_cmd == CMD_ACT) begin
      row_state <= ST_OPEN;
      open_pair <= REQ_PAIR_I;
      open_bank <= REQ_BANK_I;
      open_row  <= REQ_ROW_I;
    end else if (next_cmd == CMD_PRE_ALL) begin
      row_state <= ST_CLOSED;
    end
  end

  // ==========================================================================
  // Read capture after CAS latency
  // ==========================================================================
  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      cas_pipe  <= '0;
      RD_HALF_O <= 1'b0;
    end else begin
      cas_pipe <= {cas_pipe[CAS_PIPE-2:0], next_cmd == CMD_RD};
      if (next_cmd == CMD_RD) begin
        RD_HALF_O <= (dram_timing_reg[CL_LSB +: 2] == CL_2P5);
      end
    end
  end

  assign RD_CAPTURE_O = cas_pipe[CAS_PIPE-1];

  // ==========================================================================
  // Dynamic power-down per row pair
  // ==========================================================================
  for (genvar p = 0; p < NUM_PAIRS; p++) begin : g_pair
    cke_pair_ctrl u_cke (
      .CLK_I    (CLK_I),
      .RSTN_I   (RSTN_I),
      .enable_i (dram_mode_reg[DPD_BIT]),
      .closed_i (!(row_state == ST_OPEN && open_pair == 2'(p))),
      .wake_i   (wake_all || (REQ_VALID_I && REQ_PAIR_I == 2'(p))),
      .cke_o    (CKE_O[p])
    );
  end

endmodule

// ==== logic/spacing_timer.sv ====
// Purpose: Loadable down counter that flags when a spacing has elapsed
// Assumes: Load value is the spacing in clocks; done comes one clock before it elapses
// Notes:   Done at a count of one, so a gated command lands on its spacing
`timescale 1ns/1ps
module spacing_timer (
  input  wire logic                        CLK_I,
  input  wire logic                        RSTN_I,
  input  wire logic                        load_i,
  input  wire logic [ddr_cfg_pkg::CNT_W-1:0] value_i,
  output logic                             done_o
);
  import ddr_cfg_pkg::*;

  logic [CNT_W-1:0] count;

  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      count <= '0;
    end else if (load_i) begin
      count <= value_i;
    end else if (count != '0) begin
      count <= count - 1'b1;
    end
  end

  assign done_o = (count[CNT_W-1:1] == '0);
endmodule

// ==== testbench/ddr_mem_model.sv ====
// Purpose: Memory-side model that times command spacing
// Assumes: One command per clock
// Notes:   Gaps are DRAM clocks between the named commands
`timescale 1ns/1ps
module ddr_mem_model (
  input  wire logic              clk_i,
  input  wire logic              rstn_i,
  input  wire ddr_cfg_pkg::cmd_e cmd_i,
  output logic [15:0]            gap_rcd_o,
  output logic [15:0]            gap_ras_o,
  output logic [15:0]            gap_rp_o,
  output logic [15:0]            gap_idle_o,
  output logic [15:0]            gap_ref_o,
  output logic [15:0]            pre_cnt_o
);
  import ddr_cfg_pkg::*;
  logic [15:0] cyc, t_act, t_pre, t_rd, t_ref;
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cyc       <= 16'h0;
      pre_cnt_o <= 16'h0;
    end else begin
      cyc <= cyc + 16'h1;
      if (cmd_i == CMD_ACT) begin
        gap_rp_o <= cyc - t_pre;
        t_act    <= cyc;
      end
      if (cmd_i == CMD_RD || cmd_i == CMD_WR) begin
        gap_rcd_o <= cyc - t_act;
        t_rd      <= cyc;
      end
      if (cmd_i == CMD_PRE_ALL) begin
        gap_ras_o  <= cyc - t_act;
        gap_idle_o <= cyc - t_rd;
        pre_cnt_o  <= pre_cnt_o + 16'h1;
        t_pre      <= cyc;
      end
      if (cmd_i == CMD_REF) begin
        gap_ref_o <= cyc - t_ref;
        t_ref     <= cyc;
      end
    end
  end
endmodule

// ==== testbench/ddr_timing_mode_config_properties.sv ====
// Purpose: Assertions on command spacing, read capture and bus answers
// Assumes: Sees only top-level ports of the block
// Notes:   Bound at the foot of this file
`timescale 1ns/1ps
module ddr_timing_mode_config_properties (
  input wire logic              CLK_I,
  input wire logic              RSTN_I,
  input wire logic              ARVALID_I,
  input wire logic              ARREADY_O,
  input wire logic              RVALID_O,
  input wire logic              REQ_VALID_I,
  input wire logic              REQ_READY_O,
  input wire ddr_cfg_pkg::cmd_e CMD_O,
  input wire logic [1:0]        CMD_PAIR_O,
  input wire logic [3:0]        CKE_O,
  input wire logic              RD_CAPTURE_O
);
  import ddr_cfg_pkg::*;
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RSTN_I);
  sequence s_act; CMD_O == CMD_ACT; endsequence
  sequence s_pre; CMD_O == CMD_PRE_ALL; endsequence
  sequence s_use; CMD_O inside {CMD_ACT, CMD_RD, CMD_WR}; endsequence
  a_cas_capture: assert property (CMD_O == CMD_RD |-> ##2 RD_CAPTURE_O)
    else $error("no capture two cycles after read");
  a_capture_cause: assert property (RD_CAPTURE_O |-> $past(CMD_O, 2) == CMD_RD)
    else $error("capture without read");
  a_rcd_floor: assert property (s_act |=> CMD_O == CMD_NOP)
    else $error("access too soon after activate");
  a_ras_floor: assert property (s_act |=> (CMD_O != CMD_PRE_ALL) [*4])
    else $error("precharge too soon after activate");
  a_rp_floor: assert property (s_pre |=> CMD_O == CMD_NOP)
    else $error("command too soon after precharge");
  a_cke_access: assert property (s_use |-> CKE_O[CMD_PAIR_O])
    else $error("access to a sleeping pair");
  a_ref_awake: assert property (CMD_O == CMD_REF |-> CKE_O == 4'hf)
    else $error("refresh with clock enable low");
  a_accept_issue: assert property (REQ_VALID_I && REQ_READY_O |=> s_use)
    else $error("accepted request without access");
  a_read_answer: assert property (ARVALID_I && ARREADY_O |=> RVALID_O)
    else $error("read answer late");
endmodule
bind ddr_timing_mode_config ddr_timing_mode_config_properties checker_inst (
  .CLK_I, .RSTN_I, .ARVALID_I, .ARREADY_O, .RVALID_O, .REQ_VALID_I, .REQ_READY_O,
  .CMD_O, .CMD_PAIR_O, .CKE_O, .RD_CAPTURE_O);

// ==== testbench/tb_ddr_timing_mode_config.sv ====
// Purpose: Self-checking bench for the DDR timing and mode block
// Assumes: Refresh stays off until the last test
// Notes:   Spacing gaps come from the memory-side model
`timescale 1ns/1ps
module tb_ddr_timing_mode_config;
  import ddr_cfg_pkg::*;
  logic        CLK_I, RSTN_I, AWVALID_I, AWREADY_O, WVALID_I, WREADY_O, BVALID_O, BREADY_I;
  logic        ARVALID_I, ARREADY_O, RVALID_O, RREADY_I, REQ_VALID_I, REQ_READY_O;
  logic        REQ_WRITE_I, RD_CAPTURE_O, RD_HALF_O, ECC_CHECK_O, INIT_DONE_O;
  logic [7:0]  AWADDR_I, ARADDR_I;
  logic [31:0] WDATA_I, RDATA_O, rd;
  logic [3:0]  WSTRB_I, CKE_O;
  logic [1:0]  BRESP_O, RRESP_O, REQ_PAIR_I, REQ_BANK_I, CMD_PAIR_O, CMD_BANK_O, rsp;
  logic [12:0] REQ_ROW_I, CMD_ROW_O;
  logic [15:0] gap_rcd, gap_ras, gap_rp, gap_idle, gap_ref, pre_cnt;
  cmd_e        CMD_O;
  int          errors, checked;
  int          idle_min [4] = '{8, 16, 64, 4};
  int          ref_cyc [4] = '{64, 15600 / 20, 7800 / 20, 64000 / 20};
  ddr_timing_mode_config ddr_timing_mode_config_inst (
    .CLK_I, .RSTN_I, .AWADDR_I, .AWVALID_I, .AWREADY_O, .WDATA_I, .WSTRB_I, .WVALID_I,
    .WREADY_O, .BRESP_O, .BVALID_O, .BREADY_I, .ARADDR_I, .ARVALID_I, .ARREADY_O, .RDATA_O,
    .RRESP_O, .RVALID_O, .RREADY_I, .REQ_VALID_I, .REQ_READY_O, .REQ_WRITE_I, .REQ_PAIR_I,
    .REQ_BANK_I, .REQ_ROW_I, .CMD_O, .CMD_PAIR_O, .CMD_BANK_O, .CMD_ROW_O, .CKE_O,
    .RD_CAPTURE_O, .RD_HALF_O, .ECC_CHECK_O, .INIT_DONE_O);
  ddr_mem_model ddr_mem_model_inst (
    .clk_i(CLK_I), .rstn_i(RSTN_I), .cmd_i(CMD_O), .gap_rcd_o(gap_rcd), .gap_ras_o(gap_ras),
    .gap_rp_o(gap_rp), .gap_idle_o(gap_idle), .gap_ref_o(gap_ref), .pre_cnt_o(pre_cnt));
  initial begin
    CLK_I = 1'b0;
    forever #10 CLK_I = ~CLK_I;
  end
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic tend(input string nm);
    $display("test %s done, mismatches so far %0d", nm, errors);
  endtask
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    logic aw, w, b;
    b = 1'b0;
    @(posedge CLK_I);
    AWADDR_I <= a;
    WDATA_I <= d;
    WSTRB_I <= s;
    AWVALID_I <= 1'b1;
    WVALID_I <= 1'b1;
    BREADY_I <= 1'b1;
    while (!b) begin
      @(negedge CLK_I);
      aw = AWVALID_I && AWREADY_O;
      w = WVALID_I && WREADY_O;
      b = BVALID_O;
      rsp = BRESP_O;
      @(posedge CLK_I);
      if (aw) AWVALID_I <= 1'b0;
      if (w) WVALID_I <= 1'b0;
    end
    BREADY_I <= 1'b0;
  endtask
  task automatic axi_rd(input logic [7:0] a);
    logic ar, r;
    r = 1'b0;
    @(posedge CLK_I);
    ARADDR_I <= a;
    ARVALID_I <= 1'b1;
    RREADY_I <= 1'b1;
    while (!r) begin
      @(negedge CLK_I);
      ar = ARVALID_I && ARREADY_O;
      r = RVALID_O;
      rd = RDATA_O;
      rsp = RRESP_O;
      @(posedge CLK_I);
      if (ar) ARVALID_I <= 1'b0;
    end
    RREADY_I <= 1'b0;
  endtask
  task automatic mem_req(input logic wr, input logic [1:0] p, input logic [12:0] row);
    logic t;
    t = 1'b0;
    @(posedge CLK_I);
    REQ_VALID_I <= 1'b1;
    REQ_WRITE_I <= wr;
    REQ_PAIR_I <= p;
    REQ_BANK_I <= p;
    REQ_ROW_I <= row;
    while (!t) begin
      @(negedge CLK_I);
      t = REQ_READY_O;
      @(posedge CLK_I);
    end
    REQ_VALID_I <= 1'b0;
  endtask
  task automatic finish_test();
    $display("comparisons %0d, mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  initial begin
    repeat (40000) @(posedge CLK_I);
    errors++;
    finish_test();
  end
  initial begin
    {AWVALID_I, WVALID_I, BREADY_I, ARVALID_I, RREADY_I, REQ_VALID_I, REQ_WRITE_I} = '0;
    {AWADDR_I, ARADDR_I, WDATA_I, WSTRB_I, REQ_PAIR_I, REQ_BANK_I, REQ_ROW_I} = '0;
    RSTN_I = 1'b0;
    repeat (16) @(posedge CLK_I);
    RSTN_I <= 1'b1;
    axi_rd(DRAM_TIMING_OFS);
    chk("timing reset", 32'h0000_0010, rd);
    chk("timing resp", 32'h0, rsp);
    axi_rd(DRAM_MODE_OFS);
    chk("mode reset", 32'h0, rd);
    axi_rd(8'h40);
    chk("unmapped data", 32'h0, rd);
    chk("unmapped resp", 32'h2, rsp);
    axi_wr(DRAM_TIMING_OFS, 32'hffff_ffff, 4'h1);
    chk("write resp", 32'h0, rsp);
    axi_rd(DRAM_TIMING_OFS);
    chk("timing lane", 32'h0000_0035, rd);
    axi_wr(DRAM_TIMING_OFS, 32'hffff_ffff, 4'hf);
    axi_rd(DRAM_TIMING_OFS);
    chk("timing fields", 32'h0007_0635, rd);
    tend("registers");
    for (int i = 0; i < 3; i++) begin
      axi_wr(DRAM_TIMING_OFS, (32'(i) << TRAS_LSB) | (i[0] ? 32'h5 : 32'h10), 4'hf);
      mem_req(1'b0, 2'h0, 13'(i + 1));
      mem_req(1'b1, 2'h0, 13'(i + 16));
      repeat (4) @(posedge CLK_I);
      chk("rcd gap", 3 - i[0], gap_rcd);
      chk("cas half", 32'(i[0]), RD_HALF_O);
      chk("ras gap", 7 - i, gap_ras);
      chk("rp gap", 3 - i[0], gap_rp);
      chk("row addr", 32'(i + 16), CMD_ROW_O);
    end
    tend("spacing");
    rd = 32'(pre_cnt);
    repeat (100) @(posedge CLK_I);
    chk("idle never", rd, 32'(pre_cnt));
    for (int k = 0; k < 4; k++) begin
      axi_wr(DRAM_TIMING_OFS, 32'h10 | (32'(k == 3 ? 1 : k + 2) << IDLE_LSB), 4'hf);
      repeat (80) @(posedge CLK_I);
      mem_req(1'b0, 2'h1, 13'(k + 40));
      repeat (80) @(posedge CLK_I);
      chk("idle gap", 1, 32'(gap_idle >= idle_min[k] && gap_idle <= idle_min[k] + 3));
    end
    tend("idle");
    axi_wr(DRAM_MODE_OFS, 32'h3020_0000, 4'hf);
    repeat (4) @(posedge CLK_I);
    chk("cke asleep", 32'h0, CKE_O);
    chk("ecc on", 32'h1, ECC_CHECK_O);
    chk("init done", 32'h1, INIT_DONE_O);
    mem_req(1'b0, 2'h2, 13'h7);
    @(negedge CLK_I);
    chk("cke awake", 32'h4, CKE_O);
    repeat (60) @(posedge CLK_I);
    chk("cke asleep again", 32'h0, CKE_O);
    axi_wr(DRAM_MODE_OFS, 32'h0010_0000, 4'hf);
    @(negedge CLK_I);
    chk("ecc reserved", 32'h0, ECC_CHECK_O);
    chk("init clear", 32'h0, INIT_DONE_O);
    tend("power-down");
    for (int k = 0; k < 4; k++) begin
      axi_wr(DRAM_MODE_OFS, 32'(k == 0 ? 7 : k) << RRS_LSB, 4'hf);
      repeat (2 * ref_cyc[k] + 20) @(posedge CLK_I);
      chk("refresh gap", ref_cyc[k], 32'(gap_ref));
    end
    tend("refresh");
    finish_test();
  end
endmodule
